// >>> bench/cdhp_host.sv
// Host processor model for the parallel register port.
// Assumes a free-running clock; pins move 1 ns after rising edges.
`timescale 1ns/10ps
module cdhp_host
  import cdhp_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] rd_data_i,
  output cdhp_host_t bus_o
);
  initial bus_o = '0;
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic rs, input logic [7:0] d, input int gap);
    step();
    bus_o.rs = rs;
    bus_o.rw = 1'b0;
    bus_o.data = d;
    step();
    bus_o.strobe = 1'b1;
    repeat (4) step();
    bus_o.strobe = 1'b0;
    repeat (3) step();
    bus_o.data = ~d;
    repeat (gap) step();
  endtask
  task automatic rd(input logic rs, output logic [7:0] d);
    step();
    bus_o.rs = rs;
    bus_o.rw = 1'b1;
    bus_o.data = ~bus_o.data;
    step();
    bus_o.strobe = 1'b1;
    repeat (6) step();
    d = rd_data_i;
    bus_o.strobe = 1'b0;
    repeat (6) step();
  endtask
  task automatic instr(input logic [7:0] d);
    wr(1'b0, d, 45);
  endtask
endmodule

// >>> bench/cdhp_sva.sv
// Checker for the host port, bound to the top module's ports.
// Assumes host pins stay stable while the strobe is high.
`timescale 1ns/10ps
module cdhp_sva
  import cdhp_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC,
  parameter int CL_HALF_CYCLES = CL_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic register_select_i,
  input wire logic read_write_select_i,
  input wire logic transfer_strobe_i,
  input wire logic [DATA_W-1:0] host_data_o,
  input wire logic host_data_oe_n_o,
  input wire logic cascade_role_select_i,
  input wire logic cascade_shift_clock_o,
  input wire logic cascade_shift_clock_oe_n_o,
  input wire logic cascade_latch_i,
  input wire logic cascade_latch_oe_n_o,
  input wire logic cascade_serial_data_oe_n_o,
  input wire logic [CASC_STAGES-1:0] cascade_columns_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================
  // Helpers
  logic [7:0] gap_r;
  logic [7:0] bcnt_r;
  logic [4:0] lat_age_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) gap_r <= 8'hFF;
    else if ($changed(cascade_shift_clock_o)) gap_r <= 8'h01;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  end
  // Counting only with the select settled keeps data bytes out of the busy run.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) bcnt_r <= 8'h00;
    else if (host_data_o[7] && !register_select_i && !$past(register_select_i, 4)) begin
      if (bcnt_r != 8'hFF) bcnt_r <= bcnt_r + 8'h01;
    end else bcnt_r <= 8'h00;
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) lat_age_r <= 5'h1F;
    else if (cascade_latch_i) lat_age_r <= 5'h00;
    else if (lat_age_r != 5'h1F) lat_age_r <= lat_age_r + 5'h01;
  end
  // ==========================================================
  // Properties
  sequence s_read_req;
    $rose(transfer_strobe_i) && read_write_select_i;
  endsequence
  sequence s_drive_on;
    ##[3:5] !host_data_oe_n_o;
  endsequence
  property p_read_drive;
    s_read_req |-> s_drive_on;
  endproperty
  property p_drive_cause;
    $fell(host_data_oe_n_o) |-> read_write_select_i && transfer_strobe_i;
  endproperty
  property p_drive_release;
    $fell(transfer_strobe_i) |-> ##[1:6] host_data_oe_n_o;
  endproperty
  property p_write_quiet;
    (!read_write_select_i) [*6] |-> host_data_oe_n_o;
  endproperty
  property p_master_oe;
    cascade_role_select_i [*6] |-> !cascade_shift_clock_oe_n_o;
  endproperty
  property p_slave_oe;
    (!cascade_role_select_i) [*6] |-> cascade_serial_data_oe_n_o && cascade_latch_oe_n_o;
  endproperty
  property p_oe_group;
    cascade_shift_clock_oe_n_o == cascade_latch_oe_n_o;
  endproperty
  property p_clk_half;
    $changed(cascade_shift_clock_o) && !cascade_shift_clock_oe_n_o |-> gap_r >= CL_HALF_CYCLES;
  endproperty
  property p_busy_bound;
    bcnt_r <= BUSY_CYCLES + 3;
  endproperty
  property p_col_latch;
    $changed(cascade_columns_o) |-> lat_age_r <= 5'h14;
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data not driven in time");
  a_drive_cause: assert property (p_drive_cause)
    else $error("bus driven without a read");
  a_drive_release: assert property (p_drive_release)
    else $error("bus not released after strobe");
  a_write_quiet: assert property (p_write_quiet)
    else $error("bus driven during writes");
  a_master_oe: assert property (p_master_oe)
    else $error("master does not drive link");
  a_slave_oe: assert property (p_slave_oe)
    else $error("slave drives link");
  a_oe_group: assert property (p_oe_group)
    else $error("link enables disagree");
  a_clk_half: assert property (p_clk_half)
    else $error("link clock half period short");
  a_busy_bound: assert property (p_busy_bound)
    else $error("busy lasts too long");
  a_col_latch: assert property (p_col_latch)
    else $error("columns changed without latch");
endmodule

bind cdhp_port cdhp_sva #(.BUSY_CYCLES(BUSY_CYCLES), .CL_HALF_CYCLES(CL_HALF_CYCLES)) u_sva (
  .sys_clk_i, .arst_n_i, .register_select_i, .read_write_select_i, .transfer_strobe_i,
  .host_data_o, .host_data_oe_n_o, .cascade_role_select_i, .cascade_shift_clock_o,
  .cascade_shift_clock_oe_n_o, .cascade_latch_i, .cascade_latch_oe_n_o,
  .cascade_serial_data_oe_n_o, .cascade_columns_o);

// >>> bench/tb.sv
// Self-checking bench: host bus, scan side and cascade link of the port.
// Assumes the host model drives the bus; in slave frames the link clock runs at 30 ns.
`timescale 1ns/10ps
module tb;
  import cdhp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [6:0] pos = 7'h00;
  logic line = 1'b0;
  logic role = 1'b0;
  logic shl = 1'b0;
  logic lclk = 1'b1;
  logic llat = 1'b0;
  logic lsd = 1'b0;
  logic feed = 1'b0;
  cdhp_host_t bus;
  logic [7:0] hdo;
  logic hoe_n;
  logic [7:0] code;
  logic clk_o, clk_oe_n, lat_o, lat_oe_n, sd_o, sd_oe_n;
  logic [99:0] cols;
  int mismatches = 0;
  int checks = 0;
  wire logic [7:0] pin_d = hoe_n ? bus.data : hdo;
  wire logic pin_clk = clk_oe_n ? lclk : clk_o;
  wire logic pin_lat = lat_oe_n ? llat : lat_o;
  wire logic pin_sd = sd_oe_n ? lsd : sd_o;
  always #2 clk = ~clk;
  cdhp_host host (.clk_i(clk), .rd_data_i(pin_d), .bus_o(bus));
  // Short busy and link counts keep the run brief.
  cdhp_port #(.BUSY_CYCLES(40), .CL_HALF_CYCLES(2)) uut (
    .sys_clk_i(clk), .arst_n_i(arst_n), .register_select_i(bus.rs),
    .read_write_select_i(bus.rw), .transfer_strobe_i(bus.strobe), .host_data_i(pin_d),
    .host_data_o(hdo), .host_data_oe_n_o(hoe_n), .scan_pos_i(pos), .scan_line_i(line),
    .scan_code_o(code), .cascade_role_select_i(role), .shift_direction_select_i(shl),
    .cascade_feed_i(feed), .cascade_shift_clock_i(pin_clk), .cascade_shift_clock_o(clk_o),
    .cascade_shift_clock_oe_n_o(clk_oe_n), .cascade_latch_i(pin_lat),
    .cascade_latch_o(lat_o), .cascade_latch_oe_n_o(lat_oe_n),
    .cascade_serial_data_i(pin_sd), .cascade_serial_data_o(sd_o),
    .cascade_serial_data_oe_n_o(sd_oe_n), .cascade_columns_o(cols));
  // ==========================================================
  // Reporting
  task automatic check(input string name, input logic [99:0] got, input logic [99:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_host();
    logic [7:0] d;
    host.rd(1'b0, d);
    check("status", 100'(d), 100'h00);
    host.instr(8'h85);
    host.wr(1'b1, 8'h41, 4);
    host.wr(1'b1, 8'h42, 4);
    host.rd(1'b0, d);
    check("ptr", 100'(d), 100'h07);
    host.instr(8'h85);
    host.rd(1'b1, d);
    check("rdata", 100'(d), 100'h41);
    host.rd(1'b1, d);
    check("rdata2", 100'(d), 100'h42);
    // A second instruction lands inside the busy time on purpose.
    host.wr(1'b0, 8'h90, 3);
    host.rd(1'b0, d);
    check("busy", 100'(d[7]), 100'h1);
    host.wr(1'b0, 8'hA0, 45);
    host.rd(1'b0, d);
    check("refused", 100'(d), 100'h10);
    host.instr(8'h04);
    host.instr(8'h80);
    host.wr(1'b1, 8'h66, 4);
    host.rd(1'b0, d);
    check("wrap7", 100'(d), 100'h7F);
    host.instr(8'h06);
    host.instr(8'h7F);
    host.wr(1'b1, 8'h77, 4);
    host.rd(1'b0, d);
    check("wrap6", 100'(d), 100'h00);
  endtask
  task automatic s_scan();
    pos = 7'h7F;
    repeat (2) host.step();
    check("blank", 100'(code), 100'h20);
    pos = 7'h05;
    repeat (2) host.step();
    check("one", 100'(code), 100'h41);
    host.instr(8'h28);
    host.instr(8'hC5);
    host.wr(1'b1, 8'h55, 4);
    line = 1'b1;
    repeat (2) host.step();
    check("two", 100'(code), 100'h55);
    host.instr(8'h18);
    line = 1'b0;
    pos = 7'h3F;
    repeat (2) host.step();
    check("shift", 100'(code), 100'h66);
  endtask
  task automatic frame(input logic dir);
    logic [99:0] pat;
    logic [99:0] rev;
    pat = {25{4'hB}};
    rev = {<<{pat}};
    shl = dir;
    #7;
    // Four lead bits let the direction settle in the link domain.
    for (int i = 0; i < 104; i++) begin
      lsd = pat[(i + 96) % 100];
      #15 lclk = 1'b0;
      #15 lclk = 1'b1;
    end
    llat = 1'b1;
    #15 lclk = 1'b0;
    #15 lclk = 1'b1;
    llat = 1'b0;
    lsd = ~lsd;
    repeat (8) host.step();
    check("cols", cols, dir ? pat : rev);
  endtask
  task automatic s_master();
    int n;
    role = 1'b1;
    feed = 1'b1;
    n = 0;
    while (lat_o !== 1'b1 && n < 3000) begin
      host.step();
      n++;
    end
    check("mlat", 100'(lat_o), 100'h1);
    check("moe", 100'({clk_oe_n, lat_oe_n, sd_oe_n}), 100'h0);
    // The first frame still carries bits from before the role change.
    repeat (8) host.step();
    while (lat_o !== 1'b1 && n < 3000) begin
      host.step();
      n++;
    end
    repeat (12) host.step();
    check("mcols", cols, {100{1'b1}});
    if (n >= 3000) final_report();
    role = 1'b0;
    repeat (8) host.step();
    check("soe", 100'({clk_oe_n, lat_oe_n, sd_oe_n}), 100'h7);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) host.step();
    s_host();
    s_scan();
    frame(1'b1);
    frame(1'b0);
    s_master();
    final_report();
  end
endmodule

// >>> hw/cdhp_port.sv
// Host register port, text memory, display shift and cascade link.
// Host pins and straps are asynchronous; the cascade clock is its own domain.
`timescale 1ns/10ps
// Contract
// - Select low means instruction, high means data
// - Instruction write accepted and operation started
// - Status read gives busy and pointer
// - Data write stored into selected memory
// - Data read loads holding register from memory
// - Instruction store has no read path
// - Busy held, further instructions ignored
// - Busy clears when operation finishes
// - Address instruction loads pointer and target
// - Pointer steps after each data access
// - Text memory holds 128 bytes
// - Pointer is seven bits, direct address
// - One-line mode maps positions 00 to 7F
// - Two-line mode, 64 bytes per line
// - Display shift offsets, wraps per line
// - Master feeds one cascaded slave
// - Role select: master drives, slave receives
// - Shift register advances on falling clock
// - Direction select picks shift direction
module cdhp_port
  import cdhp_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC,
  parameter int CL_HALF_CYCLES = CL_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic register_select_i,
  input wire logic read_write_select_i,
  input wire logic transfer_strobe_i,
  input wire logic [DATA_W-1:0] host_data_i,
  output logic [DATA_W-1:0] host_data_o,
  output logic host_data_oe_n_o,
  input wire logic [ADDR_W-1:0] scan_pos_i,
  input wire logic scan_line_i,
  output logic [DATA_W-1:0] scan_code_o,
  input wire logic cascade_role_select_i,
  input wire logic shift_direction_select_i,
  input wire logic cascade_feed_i,
  input wire logic cascade_shift_clock_i,
  output logic cascade_shift_clock_o,
  output logic cascade_shift_clock_oe_n_o,
  input wire logic cascade_latch_i,
  output logic cascade_latch_o,
  output logic cascade_latch_oe_n_o,
  input wire logic cascade_serial_data_i,
  output logic cascade_serial_data_o,
  output logic cascade_serial_data_oe_n_o,
  output logic [CASC_STAGES-1:0] cascade_columns_o
);
  // ==========================================================
  // Host pin synchronisers
  cdhp_host_t host_s1_r;
  cdhp_host_t host_s2_r;
  logic strobe_d_r;
  logic rise;
  logic fall;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_s1_r <= '0;
      host_s2_r <= '0;
      strobe_d_r <= 1'b0;
    end else begin
      host_s1_r <= {register_select_i, read_write_select_i, transfer_strobe_i, host_data_i};
      host_s2_r <= host_s1_r;
      strobe_d_r <= host_s2_r.strobe;
    end
  end

  assign rise = host_s2_r.strobe && !strobe_d_r;
  assign fall = !host_s2_r.strobe && strobe_d_r;

  // ==========================================================
  // Register state
  logic [DATA_W-1:0] text_mem_r [TEXT_DEPTH];
  logic [DATA_W-1:0] glyph_mem_r [GLYPH_DEPTH];
  logic [DATA_W-1:0] data_holding_r;
  logic [ADDR_W-1:0] address_pointer_r;
  logic [ADDR_W-1:0] ptr_nxt;
  cdhp_target_t target_r;
  logic busy_r;
  logic [$clog2(BUSY_CYCLES+1)-1:0] busy_cnt_r;
  logic incr_r;
  logic two_line_r;
  logic [ADDR_W-1:0] offset_r;
  logic instr_ok;
  logic data_wr;
  logic data_rd;
  logic [DATA_W-1:0] op;

  assign op = host_s2_r.data;
  assign instr_ok = fall && !host_s2_r.rs && !host_s2_r.rw && !busy_r;
  assign data_wr = fall && host_s2_r.rs && !host_s2_r.rw;
  assign data_rd = fall && host_s2_r.rs && host_s2_r.rw;

  always_comb begin
    ptr_nxt = incr_r ? address_pointer_r + 7'h01 : address_pointer_r - 7'h01;
    if (target_r == CDHP_TGT_GLYPH) begin
      ptr_nxt[ADDR_W-1] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      address_pointer_r <= PTR_RESET;
      target_r <= CDHP_TGT_TEXT;
      incr_r <= 1'b1;
      two_line_r <= 1'b0;
      offset_r <= PTR_RESET;
    end else if (instr_ok) begin
      if (op[OP_TEXT_ADDR_BIT]) begin
        address_pointer_r <= op[ADDR_W-1:0];
        target_r <= CDHP_TGT_TEXT;
      end else if (op[OP_GLYPH_ADDR_BIT]) begin
        address_pointer_r <= {1'b0, op[ADDR_W-2:0]};
        target_r <= CDHP_TGT_GLYPH;
      end else if (op[OP_FUNC_BIT]) begin
        two_line_r <= op[FUNC_LINES_BIT];
      end else if (op[OP_SHIFT_BIT]) begin
        if (op[SHIFT_DISP_BIT]) begin
          offset_r <= op[SHIFT_RIGHT_BIT] ? offset_r - 7'h01 : offset_r + 7'h01;
        end else begin
          address_pointer_r <= op[SHIFT_RIGHT_BIT] ? address_pointer_r + 7'h01
                                                   : address_pointer_r - 7'h01;
        end
      end else if (op[OP_ENTRY_BIT]) begin
        incr_r <= op[ENTRY_INC_BIT];
      end else if (op[OP_CLEAR_BIT]) begin
        address_pointer_r <= PTR_RESET;
        target_r <= CDHP_TGT_TEXT;
        offset_r <= PTR_RESET;
        incr_r <= 1'b1;
      end
    end else if (data_wr || data_rd) begin
      address_pointer_r <= ptr_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_r <= 1'b0;
      busy_cnt_r <= '0;
    end else if (instr_ok) begin
      busy_r <= 1'b1;
      busy_cnt_r <= ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES - 1);
    end else if (busy_cnt_r != '0) begin
      busy_cnt_r <= busy_cnt_r - 1'b1;
    end else begin
      busy_r <= 1'b0;
    end
  end

  // Clearing the text fills it with blanks; the glyph store is left alone.
  // memory write
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < TEXT_DEPTH; i++) begin
        text_mem_r[i] <= CLEAR_CODE;
      end
      for (int j = 0; j < GLYPH_DEPTH; j++) begin
        glyph_mem_r[j] <= DATA_RESET;
      end
    end else if (instr_ok && op == 8'h01) begin
      for (int i = 0; i < TEXT_DEPTH; i++) begin
        text_mem_r[i] <= CLEAR_CODE;
      end
    end else if (data_wr) begin
      if (target_r == CDHP_TGT_TEXT) begin
        text_mem_r[address_pointer_r] <= op;
      end else begin
        glyph_mem_r[address_pointer_r[ADDR_W-2:0]] <= op;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_holding_r <= DATA_RESET;
    end else if (data_wr) begin
      data_holding_r <= op;
    end else if (rise && host_s2_r.rs && host_s2_r.rw) begin
      if (target_r == CDHP_TGT_TEXT) begin
        data_holding_r <= text_mem_r[address_pointer_r];
      end else begin
        data_holding_r <= glyph_mem_r[address_pointer_r[ADDR_W-2:0]];
      end
    end
  end

  // Read data is launched two cycles after the synced rise, so the host
  // must allow the synchroniser delay before sampling the bus.
  // read mux
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      host_data_o <= DATA_RESET;
      host_data_oe_n_o <= 1'b1;
    end else begin
      host_data_oe_n_o <= !(host_s2_r.strobe && host_s2_r.rw);
      if (host_s2_r.rs) begin
        host_data_o <= data_holding_r;
      end else begin
        host_data_o <= {busy_r, address_pointer_r};
      end
    end
  end

  // ==========================================================
  // Display scan with shift offset
  logic [ADDR_W-1:0] scan_addr;
  logic [ADDR_W-1:0] scan_sum;

  assign scan_sum = scan_pos_i + offset_r;
  always_comb begin
    if (two_line_r) begin
      scan_addr = {scan_line_i, scan_sum[ADDR_W-2:0]};
    end else begin
      scan_addr = scan_sum;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scan_code_o <= DATA_RESET;
    end else begin
      scan_code_o <= text_mem_r[scan_addr];
    end
  end

  // ==========================================================
  // Master frame generator on the system clock
  logic role_s1_r;
  logic role_s2_r;
  logic [$clog2(CL_HALF_CYCLES+1)-1:0] div_r;
  logic [7:0] edge_cnt_r;
  logic feed_r;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      role_s1_r <= 1'b0;
      role_s2_r <= 1'b0;
      feed_r <= 1'b0;
    end else begin
      role_s1_r <= cascade_role_select_i;
      role_s2_r <= role_s1_r;
      feed_r <= cascade_feed_i;
    end
  end

  // One frame is 100 falling edges followed by a latch pulse.
  // master drives the link
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_r <= '0;
      edge_cnt_r <= 8'h00;
      cascade_shift_clock_o <= 1'b1;
      cascade_latch_o <= 1'b0;
    end else if (!role_s2_r) begin
      div_r <= '0;
      edge_cnt_r <= 8'h00;
      cascade_shift_clock_o <= 1'b1;
      cascade_latch_o <= 1'b0;
    end else if (div_r != '0) begin
      div_r <= div_r - 1'b1;
    end else begin
      div_r <= ($clog2(CL_HALF_CYCLES+1))'(CL_HALF_CYCLES - 1);
      if (edge_cnt_r == 8'(CASC_STAGES)) begin
        // Latch spans one extra falling edge, so both ends sample it high.
        if (cascade_latch_o && !cascade_shift_clock_o) begin
          cascade_latch_o <= 1'b0;
          edge_cnt_r <= 8'h00;
        end else begin
          cascade_shift_clock_o <= !cascade_shift_clock_o;
          cascade_latch_o <= 1'b1;
        end
      end else begin
        cascade_shift_clock_o <= !cascade_shift_clock_o;
        if (cascade_shift_clock_o) begin
          edge_cnt_r <= edge_cnt_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cascade_shift_clock_oe_n_o <= 1'b1;
      cascade_latch_oe_n_o <= 1'b1;
      cascade_serial_data_oe_n_o <= 1'b1;
    end else begin
      cascade_shift_clock_oe_n_o <= !role_s2_r;
      cascade_latch_oe_n_o <= !role_s2_r;
      cascade_serial_data_oe_n_o <= !role_s2_r;
    end
  end

  // ==========================================================
  // Link domain, falling edge of the cascade shift clock
  logic dir_s1_r;
  logic dir_s2_r;
  logic lrole_s1_r;
  logic lrole_s2_r;
  logic feed_s1_r;
  logic feed_s2_r;
  logic [CASC_STAGES-1:0] shreg_r;
  logic [CASC_STAGES-1:0] held_r;
  logic lat_tgl_r;
  logic sin;

  always_ff @(negedge cascade_shift_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dir_s1_r <= 1'b0;
      dir_s2_r <= 1'b0;
      lrole_s1_r <= 1'b0;
      lrole_s2_r <= 1'b0;
      feed_s1_r <= 1'b0;
      feed_s2_r <= 1'b0;
    end else begin
      dir_s1_r <= shift_direction_select_i;
      dir_s2_r <= dir_s1_r;
      lrole_s1_r <= cascade_role_select_i;
      lrole_s2_r <= lrole_s1_r;
      feed_s1_r <= feed_r;
      feed_s2_r <= feed_s1_r;
    end
  end

  // master feeds itself, slave takes the pin
  assign sin = lrole_s2_r ? feed_s2_r : cascade_serial_data_i;

  // Stage 1 is bit 0 and stage 100 is the top bit.
  // directional shift
  always_ff @(negedge cascade_shift_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shreg_r <= '0;
      cascade_serial_data_o <= 1'b0;
    end else if (dir_s2_r) begin
      shreg_r <= {sin, shreg_r[CASC_STAGES-1:1]};
      cascade_serial_data_o <= shreg_r[0];
    end else begin
      shreg_r <= {shreg_r[CASC_STAGES-2:0], sin};
      cascade_serial_data_o <= shreg_r[CASC_STAGES-1];
    end
  end

  // The latch pin is sampled on the last falling edge of the frame; the
  // held word then crosses by a toggle and stays stable until the next.
  always_ff @(negedge cascade_shift_clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      held_r <= '0;
      lat_tgl_r <= 1'b0;
    end else if (cascade_latch_i) begin
      held_r <= shreg_r;
      lat_tgl_r <= !lat_tgl_r;
    end
  end

  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_d_r;

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r <= 1'b0;
      cascade_columns_o <= '0;
    end else begin
      tgl_s1_r <= lat_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r <= tgl_s2_r;
      if (tgl_s2_r != tgl_d_r) begin
        cascade_columns_o <= held_r;
      end
    end
  end
endmodule

// >>> pkg/cdhp_pkg.sv
// Constants and carrier types for the character display host port.
// Assumes one system clock at 250 MHz and a slow cascade shift clock.
package cdhp_pkg;
  // ==========================================================
  // Sizes
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int TEXT_DEPTH = 128;
  localparam int GLYPH_DEPTH = 64;
  localparam int CASC_STAGES = 100;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int BUSY_NS = 400;
  localparam int BUSY_CYC = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CL_HALF_NS = 60;
  localparam int CL_HALF_CYC = CL_HALF_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Instruction decode, top set bit selects the command
  localparam int OP_TEXT_ADDR_BIT = 7;
  localparam int OP_GLYPH_ADDR_BIT = 6;
  localparam int OP_FUNC_BIT = 5;
  localparam int OP_SHIFT_BIT = 4;
  localparam int OP_ENTRY_BIT = 2;
  localparam int OP_CLEAR_BIT = 0;
  localparam int FUNC_LINES_BIT = 3;
  localparam int SHIFT_DISP_BIT = 3;
  localparam int SHIFT_RIGHT_BIT = 2;
  localparam int ENTRY_INC_BIT = 1;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CLEAR_CODE = 8'h20;
  localparam logic [6:0] PTR_RESET = 7'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  typedef struct packed {
    logic rs;
    logic rw;
    logic strobe;
    logic [DATA_W-1:0] data;
  } cdhp_host_t;

  typedef enum logic {
    CDHP_TGT_TEXT,
    CDHP_TGT_GLYPH
  } cdhp_target_t;
endpackage
